// ==== src/frame_timer_pkg.sv ====
// Functional notes
// - Both bytes form 16-bit auto-reload up-counter.
// - 16-bit wrap loads reload value, sets high flag.
// - Timer interrupt on each full 16-bit overflow.
// - Low byte wrap interrupts when low enable set.
// - Split mode: two independent 8-bit reload counters.
// - Run bit gates all, or high byte only.
// - Per-byte select: system clock or alternate source.
// - High and low wraps set their overflow flags.
// - Split interrupts: high wraps, plus low if enabled.
// - Overflow flags cleared only by software writes.
// - Capture mode: 16-bit free wrap, SOF copies count.
// - Split capture: bytes wrap alone, SOF copies both.
// - Each SOF capture raises timer interrupt if enabled.
// - Low wrap sets low flag in every mode.
// - Control bit 1 reads zero, writes ignored.
// - Alternate source: 0 is /12, 1 is external /8.
// - Outside split, low select clocks whole timer.
// - High select matters only in split mode.
package frame_timer_pkg;

    // Register addresses on the special function register bus.
    localparam logic [7:0] ADDR_TIMER_CONTROL = 8'hc8;
    localparam logic [7:0] ADDR_RELOAD_LOW    = 8'hca;
    localparam logic [7:0] ADDR_RELOAD_HIGH   = 8'hcb;
    localparam logic [7:0] ADDR_COUNT_LOW     = 8'hcc;
    localparam logic [7:0] ADDR_COUNT_HIGH    = 8'hcd;

    // Bit positions inside the control register.
    localparam int BIT_HIGH_FLAG  = 7;
    localparam int BIT_LOW_FLAG   = 6;
    localparam int BIT_LOW_IRQ_EN = 5;
    localparam int BIT_FRAME_CAP  = 4;
    localparam int BIT_SPLIT      = 3;
    localparam int BIT_RUN        = 2;
    localparam int BIT_ALT_CLK    = 0;

    // Prescaler figures for the two alternate sources.
    localparam logic [3:0] SYS_DIV_LAST = 4'hb;
    localparam logic [2:0] EXT_DIV_LAST = 3'h7;

    // Byte values at which the counters wrap.
    localparam logic [7:0] BYTE_MAX   = 8'hff;
    localparam logic [7:0] BYTE_ZERO  = 8'h00;
    localparam logic [7:0] BYTE_ONE   = 8'h01;
    localparam logic [7:0] READ_ZERO  = 8'h00;

    // Complete state of the timer, registered as one word.
    typedef struct packed {
        logic [7:0] count_low;
        logic [7:0] count_high;
        logic [7:0] reload_low;
        logic [7:0] reload_high;
        logic       high_flag;
        logic       low_flag;
        logic       low_irq_en;
        logic       frame_capture;
        logic       split;
        logic       run;
        logic       alt_clk;
        logic [3:0] sys_div;
        logic [2:0] ext_sync;
        logic       ext_level;
        logic [2:0] ext_div;
        logic [7:0] rdata;
    } state_type;

    localparam state_type STATE_RESET = '0;

endpackage

// ==== src/frame_capture_reload_timer.sv ====
`timescale 1ns/1ps
module frame_capture_reload_timer (
    // Clock and synchronous active-low reset.
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Special function register bus.
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    // Clock select bits held in the shared clock configuration register.
    input  wire logic       high_byte_clock_select,
    input  wire logic       low_byte_clock_select,
    // Interrupt enable from the interrupt controller.
    input  wire logic       timer_irq_enable,
    // Start-of-frame pulse from the USB controller.
    input  wire logic       usb_sof_pulse,
    // External oscillator pin.
    input  wire logic       ext_osc_pin,
    // Interrupt request to the interrupt controller.
    output logic            timer_irq
);
    import frame_timer_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State and decoded bus strobes.

    state_type r_reg;             // Registered state.
    state_type r_next;            // Next state from the combinational block.

    logic wr_ctrl;                // Write to the control register.
    logic wr_rl;                  // Write to the reload low byte.
    logic wr_rh;                  // Write to the reload high byte.
    logic wr_cl;                  // Write to the count low byte.
    logic wr_ch;                  // Write to the count high byte.

    // Strobes are decoded straight from the bus. A write lands at the edge
    // that samples it, so a read issued in the next cycle already sees it.
    // Unmapped addresses decode to nothing and writes there are dropped.
    // No wait state is ever needed, which keeps the core's bus timing fixed.
    assign wr_ctrl = sfr_wr && (sfr_addr == ADDR_TIMER_CONTROL);
    assign wr_rl   = sfr_wr && (sfr_addr == ADDR_RELOAD_LOW);
    assign wr_rh   = sfr_wr && (sfr_addr == ADDR_RELOAD_HIGH);
    assign wr_cl   = sfr_wr && (sfr_addr == ADDR_COUNT_LOW);
    assign wr_ch   = sfr_wr && (sfr_addr == ADDR_COUNT_HIGH);

    ////////////////////////////////////////////////////////////////////////////
    // Count enables.

    logic sys_tick;               // System clock divided by twelve.
    logic ext_rise;               // Filtered rising edge of the external clock.
    logic ext_tick;               // External clock divided by eight.
    logic alt_tick;               // Alternate source chosen by the control bit.
    logic low_tick;               // Clock for the low byte, or the whole timer.
    logic high_tick;              // Clock for the high byte in split mode.
    logic low_inc;                // Low byte increments this cycle.
    logic high_inc;               // High byte increments this cycle.
    logic low_wrap;               // Low byte passes from all ones to zero.
    logic high_wrap;              // High byte passes from all ones to zero.
    logic capture;                // Start-of-frame capture this cycle.

    // Every enable below is a single-cycle pulse, or held high when a select picks the system clock,
    // so the count moves by at most one per system clock whatever the selected source.
    assign sys_tick  = (r_reg.sys_div == SYS_DIV_LAST);
    assign ext_rise  = (r_reg.ext_sync[2] == r_reg.ext_sync[1]) && r_reg.ext_sync[2] && !r_reg.ext_level;
    assign ext_tick  = ext_rise && (r_reg.ext_div == EXT_DIV_LAST);
    assign alt_tick  = r_reg.alt_clk ? ext_tick : sys_tick;
    assign low_tick  = low_byte_clock_select ? 1'b1 : alt_tick;
    // Outside split mode the high byte select is ignored altogether.
    assign high_tick = high_byte_clock_select ? 1'b1 : alt_tick;

    // In split mode the low byte runs regardless of the run bit.
    assign low_inc   = r_reg.split ? low_tick : (r_reg.run && low_tick);
    assign low_wrap  = low_inc && (r_reg.count_low == BYTE_MAX);
    // Outside split mode the high byte is the carry of the low byte.
    assign high_inc  = r_reg.split ? (r_reg.run && high_tick) : low_wrap;
    assign high_wrap = high_inc && (r_reg.count_high == BYTE_MAX);

    // The SOF pulse is taken as already synchronous and one cycle wide.
    assign capture   = r_reg.frame_capture && usb_sof_pulse;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    // One process computes the whole next state; writes override counting.
    always_comb begin
        r_next = r_reg;

        // Free-running divide-by-twelve prescaler.
        // It never stops, so the first tick after starting the timer comes
        // one to twelve cycles later. That jitter is accepted because a
        // resettable prescaler would cost a control path for little gain.
        if (sys_tick) begin
            r_next.sys_div = '0;
        end else begin
            r_next.sys_div = r_reg.sys_div + 4'h1;
        end

        // Three-stage pin synchroniser; a change counts once stages agree.
        // The first stage may go metastable, so it is only ever shifted on.
        // Requiring the second and third stages to match also rejects a
        // glitch of a single cycle, at the price of three to four cycles
        // of latency on the pin. The oscillator must stay well below half
        // the system clock or edges will be lost.
        r_next.ext_sync = {r_reg.ext_sync[1:0], ext_osc_pin};
        if (r_reg.ext_sync[2] == r_reg.ext_sync[1]) begin
            r_next.ext_level = r_reg.ext_sync[2];
        end
        // The divide-by-eight counts filtered rising edges.
        if (ext_rise) begin
            r_next.ext_div = r_reg.ext_div + 3'h1;
        end

        // Low byte: wraps to zero, or reloads in auto-reload modes.
        // In capture modes nothing reloads: the count must run freely so
        // that software can take the difference of two captures.
        // Outside split mode the low byte reloads only together with the
        // high byte, otherwise it simply rolls over and carries.
        if (low_inc) begin
            if (low_wrap) begin
                // Non-split reload only on the full sixteen-bit wrap.
                if (!r_reg.frame_capture && (r_reg.split || high_wrap)) begin
                    r_next.count_low = r_reg.reload_low;
                end else begin
                    r_next.count_low = BYTE_ZERO;
                end
            end else begin
                r_next.count_low = r_reg.count_low + BYTE_ONE;
            end
        end

        // High byte.
        if (high_inc) begin
            if (high_wrap) begin
                r_next.count_high = r_reg.frame_capture ? BYTE_ZERO : r_reg.reload_high;
            end else begin
                r_next.count_high = r_reg.count_high + BYTE_ONE;
            end
        end

        // Software writes to the counter take precedence over a tick.
        if (wr_cl) begin
            r_next.count_low = sfr_wdata;
        end
        if (wr_ch) begin
            r_next.count_high = sfr_wdata;
        end

        // Reload bytes: software write, then capture which wins a collision.
        if (wr_rl) begin
            r_next.reload_low = sfr_wdata;
        end
        if (wr_rh) begin
            r_next.reload_high = sfr_wdata;
        end
        if (capture) begin
            r_next.reload_low  = r_reg.count_low;
            r_next.reload_high = r_reg.count_high;
        end

        // Control register; bit 1 has no storage behind it.
        // The flag bits are written like any other bit; a zero clears a flag
        // unless hardware sets it again in the same cycle, below.
        if (wr_ctrl) begin
            r_next.high_flag     = sfr_wdata[BIT_HIGH_FLAG];
            r_next.low_flag      = sfr_wdata[BIT_LOW_FLAG];
            r_next.low_irq_en    = sfr_wdata[BIT_LOW_IRQ_EN];
            r_next.frame_capture = sfr_wdata[BIT_FRAME_CAP];
            r_next.split         = sfr_wdata[BIT_SPLIT];
            r_next.run           = sfr_wdata[BIT_RUN];
            r_next.alt_clk       = sfr_wdata[BIT_ALT_CLK];
        end

        // Hardware sets win over a software clear in the same cycle, and
        // nothing in hardware ever clears a flag.
        if (high_wrap || capture) begin
            r_next.high_flag = 1'b1;
        end
        if (low_wrap) begin
            r_next.low_flag = 1'b1;
        end

        // Read data is registered and answers one cycle after the strobe.
        // Reads have no side effects, so a read may be repeated freely.
        // The high byte is not latched on a low read: software reading a
        // running sixteen-bit count must stop it or read twice.
        if (sfr_rd) begin
            unique case (sfr_addr)
                ADDR_TIMER_CONTROL: begin
                    r_next.rdata = {r_reg.high_flag, r_reg.low_flag, r_reg.low_irq_en, r_reg.frame_capture,
                                    r_reg.split, r_reg.run, 1'b0, r_reg.alt_clk};
                end
                ADDR_RELOAD_LOW:  r_next.rdata = r_reg.reload_low;
                ADDR_RELOAD_HIGH: r_next.rdata = r_reg.reload_high;
                ADDR_COUNT_LOW:   r_next.rdata = r_reg.count_low;
                ADDR_COUNT_HIGH:  r_next.rdata = r_reg.count_high;
                // Unmapped addresses read as zero.
                default:          r_next.rdata = READ_ZERO;
            endcase
        end
    end

    // Single state register with synchronous reset.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            r_reg <= STATE_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    // The read word stands until the next read strobe.
    assign sfr_rdata = r_reg.rdata;
    // The enable comes from outside and is applied without a register, so
    // masking the request takes effect in the same cycle.
    // The request is a level that follows the sticky flags, so a capture or
    // overflow stays requested until software clears the flag.
    assign timer_irq = timer_irq_enable && (r_reg.high_flag || (r_reg.low_flag && r_reg.low_irq_en));

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    a_full_wrap_reload: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!r_reg.split && !r_reg.frame_capture && r_reg.run && low_tick && {r_reg.count_high, r_reg.count_low} == 16'hffff
         && !sfr_wr) |=> ({r_reg.count_high, r_reg.count_low} == {$past(r_reg.reload_high), $past(r_reg.reload_low)})
         && r_reg.high_flag)
        else $error("full wrap did not reload or flag");

    a_capture_free_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!r_reg.split && r_reg.frame_capture && r_reg.run && low_tick && {r_reg.count_high, r_reg.count_low} == 16'hffff
         && !sfr_wr) |=> {r_reg.count_high, r_reg.count_low} == 16'h0000)
        else $error("capture mode counter did not wrap to zero");

    a_sof_copies_count: assert property (@(posedge core_clk) disable iff (!rst_n)
        (capture && !sfr_wr) |=> (r_reg.reload_low == $past(r_reg.count_low))
        && (r_reg.reload_high == $past(r_reg.count_high)) && r_reg.high_flag)
        else $error("frame capture did not copy count");

    a_split_high_reload: assert property (@(posedge core_clk) disable iff (!rst_n)
        (r_reg.split && !r_reg.frame_capture && high_wrap && !sfr_wr) |=> r_reg.count_high == $past(r_reg.reload_high))
        else $error("split high byte did not reload");

    a_split_low_runs: assert property (@(posedge core_clk) disable iff (!rst_n)
        (r_reg.split && !r_reg.run && low_byte_clock_select && r_reg.count_low != BYTE_MAX && !sfr_wr)
        |=> r_reg.count_low == $past(r_reg.count_low) + BYTE_ONE)
        else $error("split low byte stopped with run clear");

    a_stopped_high_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!r_reg.run && !wr_ch) |=> $stable(r_reg.count_high))
        else $error("high byte moved with run clear");

    a_flags_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
        (r_reg.high_flag && r_reg.low_flag && !wr_ctrl) |=> (r_reg.high_flag && r_reg.low_flag))
        else $error("overflow flag cleared without write");

    a_low_wrap_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        low_wrap |=> r_reg.low_flag)
        else $error("low wrap did not set low flag");

    a_high_wrap_irq: assert property (@(posedge core_clk) disable iff (!rst_n)
        (high_wrap && timer_irq_enable) |=> (timer_irq || !timer_irq_enable))
        else $error("interrupt missing after high overflow");

    a_bit1_reads_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        (sfr_rd && sfr_addr == ADDR_TIMER_CONTROL) |=> !sfr_rdata[1])
        else $error("unused control bit read as one");

    a_one_step_only: assert property (@(posedge core_clk) disable iff (!rst_n)
        (r_reg.split && !sfr_wr && r_reg.count_low != BYTE_MAX)
        |=> (r_reg.count_low - $past(r_reg.count_low)) <= BYTE_ONE)
        else $error("low byte advanced by more than one");

    ////////////////////////////////////////////////////////////////////////////
    // Further checks on events and on what must stay still.
    // Each one excludes the bus writes that may legally move its target, so
    // a firing always means the counting logic itself went wrong.
    // The interrupt checks allow the outside enable to drop in the cycle
    // after the event, since that input is not ours to hold.

    // A low wrap with its enable set must request an interrupt.
    // Writes to control are excluded because they may clear the enable.
    a_low_wrap_irq: assert property (@(posedge core_clk) disable iff (!rst_n)
        (low_wrap && r_reg.low_irq_en && !wr_ctrl && timer_irq_enable) |=> (timer_irq || !timer_irq_enable))
        else $error("interrupt missing after low overflow");

    // Every capture must request an interrupt when enabled.
    // The high flag carries the request, so a clear cannot hide it.
    a_capture_irq: assert property (@(posedge core_clk) disable iff (!rst_n)
        (capture && timer_irq_enable) |=> (timer_irq || !timer_irq_enable))
        else $error("interrupt missing after frame capture");

    // Outside split mode a low wrap without a full wrap carries upward.
    // The low byte must restart from zero in that case.
    a_carry_into_high: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!r_reg.split && low_wrap && !high_wrap && !sfr_wr)
        |=> (r_reg.count_high == $past(r_reg.count_high) + BYTE_ONE) && (r_reg.count_low == BYTE_ZERO))
        else $error("low wrap did not carry into high byte");

    // In split reload mode the low byte reloads from its own byte.
    // Capture is off here, so the reload byte cannot move underneath.
    a_split_low_reload: assert property (@(posedge core_clk) disable iff (!rst_n)
        (r_reg.split && !r_reg.frame_capture && low_wrap && !sfr_wr) |=> r_reg.count_low == $past(r_reg.reload_low))
        else $error("split low byte did not reload");

    // In split capture mode each byte rolls over to zero.
    // A reload here would corrupt the captured difference.
    a_split_capture_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
        (r_reg.split && r_reg.frame_capture && low_wrap && !sfr_wr) |=> r_reg.count_low == BYTE_ZERO)
        else $error("split capture low byte did not wrap to zero");

    // A high wrap always sets the high flag.
    // The set must win even against a clearing write.
    a_high_wrap_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        high_wrap |=> r_reg.high_flag)
        else $error("high wrap did not set high flag");

    // Outside split mode the run bit stops the whole counter.
    // Only a direct write may then move the low byte.
    a_stopped_whole: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!r_reg.split && !r_reg.run && !wr_cl) |=> $stable(r_reg.count_low))
        else $error("low byte moved with run clear outside split");

    // Outside split mode the high byte moves only on a low carry.
    // Its own clock select therefore can have no effect.
    a_high_select_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!r_reg.split && !low_inc && !wr_ch) |=> $stable(r_reg.count_high))
        else $error("high byte moved without a low carry");

    // The prescaler must never pass its last state.
    // A stray count here would stretch the divide ratio.
    a_prescale_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
        r_reg.sys_div <= SYS_DIV_LAST)
        else $error("prescaler left its range");

    // The reload low byte changes only by a write or a capture.
    // A reload of the counter must not disturb them.
    a_reload_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!capture && !wr_rl) |=> $stable(r_reg.reload_low))
        else $error("reload low byte changed on its own");

endmodule

// ==== testbench/sfr_core_model.sv ====
`timescale 1ns/1ps
module sfr_core_model (
    // Clock.
    input  wire logic       core_clk,
    // Register bus towards the timer.
    output logic      [7:0] sfr_addr,
    output logic            sfr_wr,
    output logic            sfr_rd,
    output logic      [7:0] sfr_wdata,
    input  wire logic [7:0] sfr_rdata,
    // Frame pulse, standing in for the USB controller.
    output logic            usb_sof_pulse
);
    // Idle bus at time zero, parked on an unmapped slot.
    initial begin
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_wdata = 8'h00;
        usb_sof_pulse = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One-cycle write strobe; released data shows its inverse so stale bytes cannot pass.
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        #1;
        sfr_addr = addr;
        sfr_wdata = data;
        sfr_wr = 1'b1;
        @(posedge core_clk);
        #1;
        sfr_wr = 1'b0;
        sfr_wdata = ~data;
    endtask

    // One-cycle read strobe; data is taken one edge later, where it is valid.
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge core_clk);
        #1;
        sfr_addr = addr;
        sfr_rd = 1'b1;
        @(posedge core_clk);
        #1;
        sfr_rd = 1'b0;
        data = sfr_rdata;
    endtask

    // Frame event as a single synchronous cycle.
    task automatic sof();
        @(posedge core_clk);
        #1;
        usb_sof_pulse = 1'b1;
        @(posedge core_clk);
        #1;
        usb_sof_pulse = 1'b0;
    endtask
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb;
    import frame_timer_pkg::*;
    // Bench signals.
    logic       core_clk;
    logic       rst_n;
    logic [7:0] sfr_addr;
    logic       sfr_wr;
    logic       sfr_rd;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic       high_sel;
    logic       low_sel;
    logic       irq_en;
    logic       usb_sof_pulse;
    logic       ext_osc_pin;
    logic       timer_irq;
    int         error_cnt;
    int         checks_done;

    frame_capture_reload_timer u_dut (
        .core_clk               (core_clk),
        .rst_n                  (rst_n),
        .sfr_addr               (sfr_addr),
        .sfr_wr                 (sfr_wr),
        .sfr_rd                 (sfr_rd),
        .sfr_wdata              (sfr_wdata),
        .sfr_rdata              (sfr_rdata),
        .high_byte_clock_select (high_sel),
        .low_byte_clock_select  (low_sel),
        .timer_irq_enable       (irq_en),
        .usb_sof_pulse          (usb_sof_pulse),
        .ext_osc_pin            (ext_osc_pin),
        .timer_irq              (timer_irq)
    );
    sfr_core_model u_cpu (
        .core_clk      (core_clk),
        .sfr_addr      (sfr_addr),
        .sfr_wr        (sfr_wr),
        .sfr_rd        (sfr_rd),
        .sfr_wdata     (sfr_wdata),
        .sfr_rdata     (sfr_rdata),
        .usb_sof_pulse (usb_sof_pulse)
    );

    ////////////////////////////////////////////////////////////////////////
    // System clock, and an oscillator whose edges never meet a rising clock edge.
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        ext_osc_pin = 1'b0;
        forever #200 ext_osc_pin = ~ext_osc_pin;
    end
    // Watchdog, far beyond the roughly 1250 cycles the tests need.
    initial begin
        #2000000;
        error_cnt++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic see(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] v;
        u_cpu.rd(addr, v);
        chk($sformatf("reg %h", addr), exp, v);
    endtask
    // Counts that depend on prescaler phase are judged against a window.
    task automatic rng(input logic [7:0] addr, input logic [7:0] lo, input logic [7:0] hi);
        logic [7:0] v;
        u_cpu.rd(addr, v);
        checks_done++;
        if ((v >= lo && v <= hi) !== 1'b1) begin
            error_cnt++;
            $display("CHECK FAILED range %h expected %h to %h seen %h", addr, lo, hi, v);
        end
    endtask
    task automatic irq_is(input logic exp);
        chk("timer_irq", {7'h00, exp}, {7'h00, timer_irq});
    endtask
    task automatic wctl(input logic [7:0] v);
        u_cpu.wr(ADDR_TIMER_CONTROL, v);
    endtask
    task automatic wcnt(input logic [7:0] hi, input logic [7:0] lo);
        u_cpu.wr(ADDR_COUNT_HIGH, hi);
        u_cpu.wr(ADDR_COUNT_LOW, lo);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Runs from zero for n cycles, then clears the run bit alone.
    task automatic measure(input logic [7:0] run_v, input int n);
        wcnt(8'h00, 8'h00);
        wctl(run_v);
        cyc(n);
        wctl(run_v & 8'hfb);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        high_sel = 1'b0;
        low_sel = 1'b1;
        irq_en = 1'b1;
        error_cnt = 0;
        checks_done = 0;
        repeat (16) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        // Every register starts at zero; the unmapped slot reads zero too.
        for (int i = 0; i < 6; i++) begin
            see(ADDR_TIMER_CONTROL + 8'(i), 8'h00);
        end
        irq_is(1'b0);
        wctl(8'h02);
        see(ADDR_TIMER_CONTROL, 8'h00);
        // Full wrap of the 16-bit counter.
        u_cpu.wr(ADDR_RELOAD_LOW, 8'h34);
        u_cpu.wr(ADDR_RELOAD_HIGH, 8'h12);
        wcnt(8'hff, 8'hf0);
        wctl(8'h04);
        cyc(30);
        see(ADDR_TIMER_CONTROL, 8'hc4);
        irq_is(1'b1);
        wctl(8'hc0);
        see(ADDR_COUNT_HIGH, 8'h12);
        rng(ADDR_COUNT_LOW, 8'h35, 8'h70);
        wctl(8'h00);
        see(ADDR_TIMER_CONTROL, 8'h00);
        irq_is(1'b0);
        // Low byte wrap alone, first without and then with its enable.
        wcnt(8'h00, 8'hf8);
        wctl(8'h04);
        cyc(20);
        see(ADDR_TIMER_CONTROL, 8'h44);
        irq_is(1'b0);
        wctl(8'h64);
        irq_is(1'b1);
        wctl(8'h00);
        // Split mode: low byte runs although the run bit is clear.
        u_cpu.wr(ADDR_RELOAD_LOW, 8'h80);
        u_cpu.wr(ADDR_RELOAD_HIGH, 8'h55);
        wcnt(8'h10, 8'hf0);
        wctl(8'h08);
        cyc(30);
        see(ADDR_COUNT_HIGH, 8'h10);
        see(ADDR_TIMER_CONTROL, 8'h48);
        irq_is(1'b0);
        rng(ADDR_COUNT_LOW, 8'h80, 8'hc0);
        u_cpu.wr(ADDR_COUNT_HIGH, 8'hf8);
        wctl(8'h0c);
        cyc(120);
        irq_is(1'b1);
        wctl(8'h08);
        rng(ADDR_COUNT_HIGH, 8'h55, 8'h70);
        wctl(8'h28);
        cyc(300);
        see(ADDR_TIMER_CONTROL, 8'h68);
        irq_is(1'b1);
        // Clock sources; the high select must not matter outside split mode.
        measure(8'h0c, 120);
        rng(ADDR_COUNT_HIGH, 8'h09, 8'h0b);
        measure(8'h0d, 320);
        rng(ADDR_COUNT_HIGH, 8'h08, 8'h0b);
        high_sel = 1'b1;
        low_sel = 1'b0;
        measure(8'h04, 120);
        rng(ADDR_COUNT_LOW, 8'h09, 8'h0b);
        see(ADDR_COUNT_HIGH, 8'h00);
        // Frame capture, whole and split.
        wcnt(8'hab, 8'hcd);
        wctl(8'h10);
        u_cpu.sof();
        see(ADDR_RELOAD_HIGH, 8'hab);
        see(ADDR_RELOAD_LOW, 8'hcd);
        irq_is(1'b1);
        irq_en = 1'b0;
        cyc(1);
        irq_is(1'b0);
        #1;
        irq_en = 1'b1;
        low_sel = 1'b1;
        wcnt(8'hff, 8'hf0);
        wctl(8'h14);
        cyc(30);
        wctl(8'h10);
        see(ADDR_COUNT_HIGH, 8'h00);
        low_sel = 1'b0;
        wcnt(8'h77, 8'h40);
        wctl(8'h18);
        u_cpu.sof();
        see(ADDR_RELOAD_HIGH, 8'h77);
        rng(ADDR_RELOAD_LOW, 8'h40, 8'h41);
        conclude();
    end
endmodule
